// *** core/duart_regs_pkg.sv ***
// How it works
// - status bits: ip change, B, counter, A
// - aux: baud set, timer mode, change enables
// - 16-bit preset from two byte registers
// - mode pointer: reset/pointer command to one, MR1 access advances
// - rts pins follow output bits zero and one
// - flow control drops rts on start, fifo full
// - output bit kept, rts back when space
// - rx interrupt select: ready or full
// - selected rx status drives pins four and five
// - character mode: errors of top character only
// - block mode: errors ORed since error reset
// - with/force parity: add and check parity
// - parity field 11 means multidrop
// - parity type: odd/even, forced level, address bit
// - data bit count excludes start, parity, stop
// - select 0 ready, 1 full; error 0 char
// - parity 00 with, 01 force, 10 none
// - parity type 0 even, 1 odd
// - block errors held until error/receiver reset
package duart_regs_pkg;
  // ==========================================================
  // bus map, byte addresses
  localparam int        ADDR_W        = 6;
  localparam int        CH_SEL_BIT    = 5;
  localparam logic [4:0] OFF_MR       = 5'h00;
  localparam logic [4:0] OFF_SR       = 5'h04;
  localparam logic [4:0] OFF_CMD      = 5'h08;
  localparam logic [5:0] OFF_INPUT_CHANGE_ACR = 6'h10;
  localparam logic [5:0] OFF_ISR_IMR  = 6'h14;
  localparam logic [5:0] OFF_CTU      = 6'h18;
  localparam logic [5:0] OFF_CTL      = 6'h1C;
  localparam logic [5:0] OFF_IP_OUTPUT_PIN_CONFIG  = 6'h34;
  localparam logic [5:0] OFF_OPR_SET  = 6'h38;
  localparam logic [5:0] OFF_OPR_CLR  = 6'h3C;
  // ==========================================================
  // fields
  localparam int MR1_RTS_BIT   = 7;
  localparam int MR1_RXINT_BIT = 6;
  localparam int MR1_ERR_BIT   = 5;
  localparam int MR1_PAR_HI    = 4;
  localparam int MR1_PAR_LO    = 3;
  localparam int MR1_PTYPE_BIT = 2;
  localparam int MR1_BPC_HI    = 1;
  localparam int CMD_HI        = 6;
  localparam int CMD_LO        = 4;
  localparam logic [2:0] CMD_SET_PTR   = 3'h1;
  localparam logic [2:0] CMD_RX_RESET  = 3'h2;
  localparam logic [2:0] CMD_ERR_RESET = 3'h4;
  localparam logic [2:0] CMD_BRK_RESET = 3'h5;
  localparam logic [1:0] PAR_WITH  = 2'h0;
  localparam logic [1:0] PAR_FORCE = 2'h1;
  localparam logic [1:0] PAR_NONE  = 2'h2;
  localparam logic [1:0] PAR_MULTI = 2'h3;
  localparam logic [3:0] DATA_BITS_BASE = 4'h5;
  localparam int ISR_CH_STRIDE = 4;
  localparam int ISR_TX        = 0;
  localparam int ISR_RX        = 1;
  localparam int ISR_DBRK      = 2;
  localparam int ISR_CTR       = 3;
  localparam int ISR_IPC       = 7;
  localparam int ACR_BRG_BIT   = 7;
  localparam int ACR_CT_HI     = 6;
  localparam int ACR_CT_LO     = 4;
  localparam int OP_RTS        = 0;
  localparam int OP_RXINT      = 4;
  localparam int OP_TXRDY      = 6;
  localparam logic [7:0] REG_RESET = 8'h00;
  typedef enum logic {PTR_MR1 = 1'b0, PTR_MR2 = 1'b1} mr_ptr_e;
endpackage : duart_regs_pkg

// *** core/duart_mode_irq_regs.sv ***
// Implementation choices: the address map and the APB register port.
`timescale 1ns/10ps
module duart_mode_irq_regs (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [duart_regs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic [1:0]                    rx_ready,
  input  wire logic [1:0]                    rx_fifo_full,
  input  wire logic [1:0]                    tx_ready,
  input  wire logic [1:0]                    rx_start_bit,
  input  wire logic [1:0]                    rx_top_load,
  input  wire logic [1:0]                    rx_top_framing,
  input  wire logic [1:0]                    rx_top_parity,
  input  wire logic [1:0]                    rx_top_break,
  input  wire logic [1:0]                    break_change,
  input  wire logic                          counter_ready,
  input  wire logic [3:0]                    input_pins,
  output logic      [7:0]                    output_pins,
  output logic                               irq_n,
  output logic      [1:0]                    rx_reset,
  output logic      [1:0]                    tx_parity_en,
  output logic      [1:0]                    rx_parity_check,
  output logic      [1:0]                    parity_odd,
  output logic      [1:0]                    multidrop,
  output logic      [7:0]                    data_bits,
  output logic      [15:0]                   mode_two,
  output logic                               baud_set2,
  output logic      [2:0]                    ct_mode,
  output logic      [15:0]                   timer_preset
);
  import duart_regs_pkg::*;

  // ==========================================================
  // bus phases and decode
  logic        setup;
  logic        access;
  logic        wr;
  logic        rd;
  logic [7:0]  wbyte;
  logic        hit;
  logic [7:0]  rd_val;
  logic [15:0] ch_rdata;
  logic [7:0]  interrupt_status;
  logic [7:0]  prdata_ff;
  logic [7:0]  nxt_prdata;

  // zero wait states: every access completes in its first access cycle
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign wbyte   = pwdata[7:0];
  assign pready  = access;
  assign pslverr = access & ~hit;
  assign prdata  = {24'h000000, prdata_ff};

  // ==========================================================
  // global registers
  logic [7:0] acr_ff;
  logic [7:0] nxt_acr;
  logic [7:0] imr_ff;
  logic [7:0] nxt_imr;
  logic [7:0] ctu_ff;
  logic [7:0] nxt_ctu;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] output_pin_config_ff;
  logic [7:0] nxt_output_pin_config;
  logic [7:0] opr_ff;
  logic [7:0] nxt_opr;
  logic [3:0] pins_ff;
  logic [3:0] nxt_pins;
  logic [3:0] delta_ff;
  logic [3:0] nxt_delta;
  logic       ctr_ff;
  logic       nxt_ctr;
  logic       irq_n_ff;
  logic       nxt_irq_n;

  // read decode; channel regions have bit 4 of the address clear
  always_comb begin
    hit    = 1'b0;
    rd_val = REG_RESET;
    if (!paddr[4]) begin
      hit    = (paddr[4:0] == OFF_MR) | (paddr[4:0] == OFF_SR & ~pwrite)
             | (paddr[4:0] == OFF_CMD & pwrite);
      rd_val = ch_rdata[paddr[CH_SEL_BIT]*8 +: 8];
    end else begin
      case (paddr)
        OFF_INPUT_CHANGE_ACR: begin
          hit    = 1'b1;
          rd_val = {delta_ff, input_pins};
        end
        OFF_ISR_IMR: begin
          hit    = 1'b1;
          rd_val = interrupt_status;
        end
        OFF_CTU, OFF_CTL: hit = pwrite;
        OFF_IP_OUTPUT_PIN_CONFIG: begin
          hit    = 1'b1;
          rd_val = {4'h0, input_pins};
        end
        OFF_OPR_SET: hit = pwrite;
        OFF_OPR_CLR: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // read data captured in setup so the access cycle answers at once
  always_comb begin
    nxt_prdata = prdata_ff;
    if (setup) begin
      nxt_prdata = pwrite ? REG_RESET : rd_val;
    end
  end

  // write-only control and the sticky global flags
  always_comb begin
    nxt_acr   = acr_ff;
    nxt_imr   = imr_ff;
    nxt_ctu   = ctu_ff;
    nxt_ctl   = ctl_ff;
    nxt_output_pin_config  = output_pin_config_ff;
    nxt_opr   = opr_ff;
    nxt_pins  = input_pins;
    nxt_delta = delta_ff;
    nxt_ctr   = ctr_ff;
    if (wr) begin
      case (paddr)
        OFF_INPUT_CHANGE_ACR: nxt_acr  = wbyte;
        OFF_ISR_IMR:  nxt_imr  = wbyte;
        OFF_CTU:      nxt_ctu  = wbyte;
        OFF_CTL:      nxt_ctl  = wbyte;
        OFF_IP_OUTPUT_PIN_CONFIG:  nxt_output_pin_config = wbyte;
        OFF_OPR_SET:  nxt_opr  = opr_ff | wbyte;
        OFF_OPR_CLR:  nxt_opr  = opr_ff & ~wbyte;
        default:      nxt_opr  = opr_ff;
      endcase
    end
    // only input change flags that were shown to software are cleared by the read
    if (rd && paddr == OFF_INPUT_CHANGE_ACR) begin
      nxt_delta = delta_ff & ~prdata_ff[7:4];
    end
    if (rd && paddr == OFF_OPR_CLR) begin
      nxt_ctr = 1'b0;
    end
    // set after clear: an event in the clearing cycle survives
    nxt_delta = nxt_delta | (input_pins ^ pins_ff);
    nxt_ctr   = nxt_ctr | counter_ready;
    nxt_irq_n = ~|(interrupt_status & imr_ff);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= REG_RESET;
      acr_ff    <= REG_RESET;
      imr_ff    <= REG_RESET;
      ctu_ff    <= REG_RESET;
      ctl_ff    <= REG_RESET;
      output_pin_config_ff   <= REG_RESET;
      opr_ff    <= REG_RESET;
      pins_ff   <= 4'h0;
      delta_ff  <= 4'h0;
      ctr_ff    <= 1'b0;
      irq_n_ff  <= 1'b1;
    end else begin
      prdata_ff <= nxt_prdata;
      acr_ff    <= nxt_acr;
      imr_ff    <= nxt_imr;
      ctu_ff    <= nxt_ctu;
      ctl_ff    <= nxt_ctl;
      output_pin_config_ff   <= nxt_output_pin_config;
      opr_ff    <= nxt_opr;
      pins_ff   <= nxt_pins;
      delta_ff  <= nxt_delta;
      ctr_ff    <= nxt_ctr;
      irq_n_ff  <= nxt_irq_n;
    end
  end

  // global status bits; channel bits come from the loop below
  assign interrupt_status[ISR_IPC]   = |(delta_ff & acr_ff[3:0]);
  assign interrupt_status[ISR_CTR]   = ctr_ff;
  assign irq_n          = irq_n_ff;
  assign baud_set2      = acr_ff[ACR_BRG_BIT];
  assign ct_mode        = acr_ff[ACR_CT_HI:ACR_CT_LO];
  assign timer_preset   = {ctu_ff, ctl_ff};
  assign output_pins[2] = ~opr_ff[2];
  assign output_pins[3] = ~opr_ff[3];

  // ==========================================================
  // per-channel mode, error and flow control state
  genvar ch;
  for (ch = 0; ch < 2; ch++) begin : g_ch
    logic       ch_hit;
    logic       mr_acc;
    logic       cmd_wr;
    logic [2:0] cmd;
    logic [2:0] top_err;
    logic [2:0] shown_err;
    logic       rx_int;
    logic [7:0] sr;
    logic [7:0] mr1_ff;
    logic [7:0] nxt_mr1;
    logic [7:0] mr2_ff;
    logic [7:0] nxt_mr2;
    mr_ptr_e    ptr_ff;
    mr_ptr_e    nxt_ptr;
    logic [2:0] err_acc_ff;
    logic [2:0] nxt_err_acc;
    logic       rts_block_ff;
    logic       nxt_rts_block;
    logic       dbrk_ff;
    logic       nxt_dbrk;
    logic       rx_reset_ff;
    logic       nxt_rx_reset;

    assign ch_hit  = ~paddr[4] & (paddr[CH_SEL_BIT] == 1'(ch));
    assign mr_acc  = access & ch_hit & (paddr[4:0] == OFF_MR);
    assign cmd_wr  = wr & ch_hit & (paddr[4:0] == OFF_CMD);
    assign cmd     = wbyte[CMD_HI:CMD_LO];
    assign top_err = {rx_top_break[ch], rx_top_framing[ch], rx_top_parity[ch]};
    // error mode 0 shows the top character only
    assign shown_err = mr1_ff[MR1_ERR_BIT] ? err_acc_ff : top_err;
    // 0 picks receiver ready, 1 picks fifo full
    assign rx_int  = mr1_ff[MR1_RXINT_BIT] ? rx_fifo_full[ch] : rx_ready[ch];
    assign sr      = {shown_err, 2'h0, tx_ready[ch], rx_fifo_full[ch], rx_ready[ch]};
    assign ch_rdata[ch*8 +: 8] = (paddr[4:0] == OFF_SR) ? sr
                               : (ptr_ff == PTR_MR1) ? mr1_ff : mr2_ff;

    always_comb begin
      nxt_mr1       = mr1_ff;
      nxt_mr2       = mr2_ff;
      nxt_ptr       = ptr_ff;
      nxt_err_acc   = err_acc_ff;
      nxt_rts_block = rts_block_ff;
      nxt_dbrk      = dbrk_ff;
      nxt_rx_reset  = 1'b0;
      // mode register pointer: a first-register access advances it, the set-pointer command resets it
      if (mr_acc && ptr_ff == PTR_MR1) begin
        nxt_ptr = PTR_MR2;
        if (pwrite) begin
          nxt_mr1 = wbyte;
        end
      end else if (mr_acc && pwrite) begin
        nxt_mr2 = wbyte;
      end
      if (cmd_wr) begin
        case (cmd)
          CMD_SET_PTR:   nxt_ptr = PTR_MR1;
          CMD_RX_RESET: begin
            nxt_err_acc  = 3'h0;
            nxt_rx_reset = 1'b1;
          end
          CMD_ERR_RESET: nxt_err_acc = 3'h0;
          CMD_BRK_RESET: nxt_dbrk = 1'b0;
          default:       nxt_ptr = nxt_ptr;
        endcase
      end
      // a character reaching the top in the clear cycle is still counted
      if (rx_top_load[ch]) begin
        nxt_err_acc = nxt_err_acc | top_err;
      end
      nxt_dbrk = nxt_dbrk | break_change[ch];
      // flow control never touches the output bit itself
      if (!rx_fifo_full[ch]) begin
        nxt_rts_block = 1'b0;
      end else if (mr1_ff[MR1_RTS_BIT] && rx_start_bit[ch]) begin
        nxt_rts_block = 1'b1;
      end
      if (!mr1_ff[MR1_RTS_BIT]) begin
        nxt_rts_block = 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mr1_ff       <= REG_RESET;
        mr2_ff       <= REG_RESET;
        ptr_ff       <= PTR_MR1;
        err_acc_ff   <= 3'h0;
        rts_block_ff <= 1'b0;
        dbrk_ff      <= 1'b0;
        rx_reset_ff  <= 1'b0;
      end else begin
        mr1_ff       <= nxt_mr1;
        mr2_ff       <= nxt_mr2;
        ptr_ff       <= nxt_ptr;
        err_acc_ff   <= nxt_err_acc;
        rts_block_ff <= nxt_rts_block;
        dbrk_ff      <= nxt_dbrk;
        rx_reset_ff  <= nxt_rx_reset;
      end
    end

    // status bits in the summary register, stride four per channel
    assign interrupt_status[ch*ISR_CH_STRIDE + ISR_TX]   = tx_ready[ch];
    assign interrupt_status[ch*ISR_CH_STRIDE + ISR_RX]   = rx_int;
    assign interrupt_status[ch*ISR_CH_STRIDE + ISR_DBRK] = dbrk_ff;

    // pins are active low: a set output bit drives the pin low unless rts is blocked or the pin is switched to show status
    assign output_pins[OP_RTS + ch]   = ~(opr_ff[OP_RTS + ch] & ~rts_block_ff);
    assign output_pins[OP_RXINT + ch] = output_pin_config_ff[OP_RXINT + ch] ? ~rx_int
                                      : ~opr_ff[OP_RXINT + ch];
    assign output_pins[OP_TXRDY + ch] = output_pin_config_ff[OP_TXRDY + ch] ? ~tx_ready[ch]
                                      : ~opr_ff[OP_TXRDY + ch];

    // character format handed to the serial engines
    assign tx_parity_en[ch]    = (mr1_ff[MR1_PAR_HI:MR1_PAR_LO] == PAR_WITH)
                               | (mr1_ff[MR1_PAR_HI:MR1_PAR_LO] == PAR_FORCE);
    assign rx_parity_check[ch] = tx_parity_en[ch];
    assign multidrop[ch]       = (mr1_ff[MR1_PAR_HI:MR1_PAR_LO] == PAR_MULTI);
    // type bit: odd/even, forced level or address flag; unused with no parity
    assign parity_odd[ch]      = (mr1_ff[MR1_PAR_HI:MR1_PAR_LO] != PAR_NONE)
                               & mr1_ff[MR1_PTYPE_BIT];
    // data bits only; start, parity and stop are counted elsewhere
    assign data_bits[ch*4 +: 4] = DATA_BITS_BASE
                                + {2'h0, mr1_ff[MR1_BPC_HI:0]};
    assign mode_two[ch*8 +: 8]  = mr2_ff;
    assign rx_reset[ch]         = rx_reset_ff;
  end

endmodule : duart_mode_irq_regs

// *** testbench/duart_mode_irq_regs_checker.sv ***
`timescale 1ns/10ps
module duart_mode_irq_regs_checker (
  input wire logic                               pclk,
  input wire logic                               presetn,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [duart_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                        pwdata,
  input wire logic [31:0]                        prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire logic [1:0]                         rx_start_bit,
  input wire logic [1:0]                         rx_fifo_full,
  input wire logic [7:0]                         output_pins,
  input wire logic [1:0]                         rx_reset,
  input wire logic [1:0]                         tx_parity_en,
  input wire logic [1:0]                         parity_odd,
  input wire logic [1:0]                         multidrop,
  input wire logic [7:0]                         data_bits,
  input wire logic [15:0]                        timer_preset
);
  import duart_regs_pkg::*;
  // ==========
  // bus qualifiers
  logic wr;
  logic cmd_rx;
  assign wr = psel && penable && pwrite;
  assign cmd_rx = wr && paddr == {1'b0, OFF_CMD} && pwdata[6:4] == CMD_RX_RESET;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // bus answer
  chk_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  // ==========
  // rts flow control, pin high means negated
  chk_rts_negate: assert property ($rose(output_pins[0]) && !$past(wr) |->
    $past(rx_start_bit[0] && rx_fifo_full[0])) else $error("rts negated without cause");
  chk_rts_return: assert property ($fell(output_pins[0]) && !$past(wr) &&
    !$past(wr, 2) |-> $past(!rx_fifo_full[0])) else $error("rts asserted while fifo full");
  // ==========
  // config outputs
  chk_rx_reset_cause: assert property (rx_reset[0] |->
    ($past(cmd_rx) || $past(cmd_rx, 2)) ##1 !rx_reset[0]) else $error("stray rx reset");
  chk_bits_range: assert property (data_bits[3:0] >= 4'h5 && data_bits[3:0] <= 4'h8)
    else $error("data bit count out of range");
  chk_no_parity_odd: assert property (!tx_parity_en[0] && !multidrop[0] |->
    !parity_odd[0]) else $error("parity type active without parity");
  chk_preset_stable: assert property (!$past(wr) |-> $stable(timer_preset))
    else $error("preset changed without write");
  cover property (wr);
  cover property ($rose(output_pins[0]));
  cover property (pslverr);
endmodule : duart_mode_irq_regs_checker

// *** testbench/rx_far_end.sv ***
`timescale 1ns/10ps
module rx_far_end (
  input  wire logic       pclk,
  input  wire logic [1:0] rx_reset,
  output logic      [1:0] rx_ready,
  output logic      [1:0] rx_fifo_full,
  output logic      [1:0] rx_start_bit,
  output logic      [1:0] rx_top_load,
  output logic      [1:0] rx_top_framing,
  output logic      [1:0] rx_top_parity,
  output logic      [1:0] rx_top_break
);
  // ==========
  // idle line: empty fifo, no errors
  initial begin
    {rx_ready, rx_fifo_full, rx_start_bit, rx_top_load} = 8'h00;
    {rx_top_framing, rx_top_parity, rx_top_break} = 6'h00;
  end
  // a channel 0 receiver reset clears its ready flag
  always @(posedge pclk) begin
    if (rx_reset[0]) begin
      rx_ready[0] <= 1'b0;
    end
  end
  // new character at the top, gap lets the sender be slow
  task automatic char_in(input int ch, input int gap, input logic fe, pe, brk);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    rx_top_load[ch] <= 1'b1;
    rx_ready[ch] <= 1'b1;
    {rx_top_framing[ch], rx_top_parity[ch], rx_top_break[ch]} <= {fe, pe, brk};
    @(posedge pclk);
    rx_top_load[ch] <= 1'b0;
  endtask : char_in
  // valid start bit seen on the line
  task automatic start_bit(input int ch);
    @(posedge pclk);
    rx_start_bit[ch] <= 1'b1;
    @(posedge pclk);
    rx_start_bit[ch] <= 1'b0;
  endtask : start_bit
  task automatic set_full(input int ch, input logic v);
    @(posedge pclk);
    rx_fifo_full[ch] <= v;
  endtask : set_full
endmodule : rx_far_end

// *** testbench/test_duart_mode_irq_regs.sv ***
`timescale 1ns/10ps
module test_duart_mode_irq_regs;
  import duart_regs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, counter_ready = 0;
  logic [5:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, irq_n, baud_set2, er;
  logic [1:0]  rx_ready, rx_fifo_full, rx_start_bit, rx_top_load, rx_top_framing;
  logic [1:0]  rx_top_parity, rx_top_break, rx_reset, tx_parity_en, rx_parity_check;
  logic [1:0]  parity_odd, multidrop, tx_ready = 0, break_change = 0;
  logic [3:0]  input_pins = 4'h5;
  logic [7:0]  output_pins, data_bits, rd;
  logic [15:0] mode_two, timer_preset;
  logic [2:0]  ct_mode;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  // ==========
  // clock and hang guard
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      stop_test();
    end
  end
  duart_mode_irq_regs duart_mode_irq_regs_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rx_ready, .rx_fifo_full, .tx_ready, .rx_start_bit,
    .rx_top_load, .rx_top_framing, .rx_top_parity, .rx_top_break, .break_change,
    .counter_ready, .input_pins, .output_pins, .irq_n, .rx_reset, .tx_parity_en,
    .rx_parity_check, .parity_odd, .multidrop, .data_bits, .mode_two, .baud_set2, .ct_mode,
    .timer_preset);
  rx_far_end rx_far_end_i (.pclk, .rx_reset, .rx_ready, .rx_fifo_full, .rx_start_bit,
    .rx_top_load, .rx_top_framing, .rx_top_parity, .rx_top_break);
  // ==========
  // helpers
  task chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one apb transfer, held until pready
  task apb(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state limit here; only the cycle guard ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdc(input logic [5:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rd, e);
  endtask : rdc
  // pointer back to mode one, then write it
  task mr1(input logic [7:0] v);
    apb(1'b1, 6'h08, 8'h10);
    apb(1'b1, 6'h00, v);
    tick(1);
  endtask : mr1
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ==========
  // scenarios
  task t_mode;
    rdc(6'h00, 8'h00, "mode one reset");
    apb(1'b1, 6'h00, 8'h5A);
    mr1(8'h83);
    apb(1'b1, 6'h08, 8'h10);
    rdc(6'h00, 8'h83, "mode one");
    rdc(6'h00, 8'h5A, "mode two");
    rdc(6'h00, 8'h5A, "mode two again");
    chk("mode_two", mode_two[7:0], 8'h5A);
    for (int j = 0; j < 4; j++) begin
      mr1({3'b000, j[1:0], 1'b1, ~j[1:0]});
      chk("data_bits", data_bits[3:0], 16'(8 - j));
      chk("tx_parity_en", tx_parity_en[0], j < 2);
      chk("rx_parity_check", rx_parity_check[0], j < 2);
      chk("multidrop", multidrop[0], j == 3);
      chk("parity_odd", parity_odd[0], j != 2);
    end
    $display("mode test done");
  endtask : t_mode
  task t_irq;
    rdc(OFF_INPUT_CHANGE_ACR, 8'h55, "input change");
    rdc(OFF_INPUT_CHANGE_ACR, 8'h05, "input change cleared");
    apb(1'b1, OFF_INPUT_CHANGE_ACR, 8'hD1);
    tick(1);
    chk("baud_set2", baud_set2, 1'b1);
    chk("ct_mode", ct_mode, 3'h5);
    input_pins <= 4'h4;
    counter_ready <= 1'b1;
    break_change <= 2'b10;
    tx_ready <= 2'b11;
    @(posedge pclk);
    counter_ready <= 1'b0;
    break_change <= 2'b00;
    tick(3);
    rdc(OFF_ISR_IMR, 8'hD9, "interrupt_status");
    chk("irq_n masked", irq_n, 1'b1);
    apb(1'b1, OFF_ISR_IMR, 8'h08);
    tick(2);
    chk("irq_n counter", irq_n, 1'b0);
    apb(1'b0, OFF_OPR_CLR, 8'h00);
    tick(2);
    chk("irq_n cleared", irq_n, 1'b1);
    apb(1'b1, OFF_CTU, 8'hA5);
    apb(1'b1, OFF_CTL, 8'h3C);
    tick(1);
    chk("timer_preset", timer_preset, 16'hA53C);
    apb(1'b0, OFF_CTU, 8'h00);
    chk("write-only read error", {er, rd}, 9'h100);
    $display("interrupt test done");
  endtask : t_irq
  task t_rx;
    apb(1'b1, OFF_ISR_IMR, 8'h02);
    mr1(8'h00);
    rx_far_end_i.char_in(0, 2, 1'b0, 1'b0, 1'b0);
    tick(2);
    apb(1'b0, OFF_ISR_IMR, 8'h00);
    chk("rx ready source", rd[1], 1'b1);
    chk("irq_n rx", irq_n, 1'b0);
    mr1(8'h40);
    apb(1'b0, OFF_ISR_IMR, 8'h00);
    chk("full source empty", rd[1], 1'b0);
    rx_far_end_i.set_full(0, 1'b1);
    tick(2);
    apb(1'b0, OFF_ISR_IMR, 8'h00);
    chk("full source", rd[1], 1'b1);
    apb(1'b1, OFF_IP_OUTPUT_PIN_CONFIG, 8'h10);
    tick(1);
    chk("pin four", output_pins[4], 1'b0);
    apb(1'b1, OFF_OPR_SET, 8'h01);
    tick(1);
    chk("rts set", output_pins[0], 1'b0);
    rx_far_end_i.start_bit(0);
    tick(2);
    chk("rts no flow", output_pins[0], 1'b0);
    mr1(8'hC0);
    rx_far_end_i.start_bit(0);
    tick(2);
    chk("rts negated", output_pins[0], 1'b1);
    rx_far_end_i.set_full(0, 1'b0);
    tick(2);
    chk("rts back", output_pins[0], 1'b0);
    apb(1'b1, OFF_OPR_CLR, 8'h01);
    tick(1);
    chk("rts cleared", output_pins[0], 1'b1);
    $display("receiver test done");
  endtask : t_rx
  task t_err;
    mr1(8'h00);
    rx_far_end_i.char_in(0, 0, 1'b1, 1'b0, 1'b1);
    rdc(6'h04, 8'hC5, "char errors");
    rx_far_end_i.char_in(0, 0, 1'b0, 1'b0, 1'b0);
    rdc(6'h04, 8'h05, "char errors gone");
    mr1(8'h20);
    apb(1'b1, 6'h08, 8'h40); // drop what character mode gathered
    rx_far_end_i.char_in(0, 3, 1'b0, 1'b1, 1'b0);
    rx_far_end_i.char_in(0, 0, 1'b0, 1'b0, 1'b0);
    rdc(6'h04, 8'h25, "block errors");
    apb(1'b1, 6'h08, 8'h40);
    rdc(6'h04, 8'h05, "error reset");
    rx_far_end_i.char_in(0, 0, 1'b1, 1'b0, 1'b0);
    rx_far_end_i.char_in(0, 0, 1'b0, 1'b0, 1'b0);
    apb(1'b1, 6'h08, 8'h20);
    tick(2);
    rdc(6'h04, 8'h04, "receiver reset");
    $display("error test done");
  endtask : t_err
  // main sequence
  initial begin
    tick(3);
    chk("reset pins", output_pins, 8'hFF);
    presetn <= 1'b1;
    t_mode();
    t_irq();
    t_rx();
    t_err();
    stop_test();
  end
endmodule : test_duart_mode_irq_regs
bind duart_mode_irq_regs duart_mode_irq_regs_checker duart_mode_irq_regs_checker_i (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rx_start_bit, .rx_fifo_full, .output_pins, .rx_reset, .tx_parity_en, .parity_odd,
  .multidrop, .data_bits, .timer_preset);
